// file: logic/fst_pkg.sv
// Shared constants for the floating-point spill trap unit.
package fst_pkg;
    localparam int WORD_W = 36;
    localparam int ADDR_W = 15;
    localparam int CODE_W = 4;
    // Storage word 0000 receives the trap record.
    localparam logic [14:0] TRAP_RECORD_ADDR = 15'h0000;
    // Next instruction after the record is fetched from octal 0010.
    localparam logic [14:0] TRAP_VECTOR_ADDR = 15'h0008;
    // Word positions counted from S (index 35) down to position 35 (index 0).
    localparam int ADDR_FIELD_LSB = 0;
    localparam int CODE_FIELD_LSB = 18;
    // Spill code bits inside the four-bit code, position 14 is the top bit.
    localparam int CODE_DIV = 3;
    localparam int CODE_OVF = 2;
    localparam int CODE_ACC = 1;
    localparam int CODE_MQ = 0;
    // Instruction hold register: sign is index 35, position 9 is index 26.
    localparam int HOLD_SIGN_IDX = 35;
    localparam int HOLD_BIT9_IDX = 26;
    localparam logic TRAP_MODE_RESET = 1'b1;
endpackage

// file: logic/fst_spill_if.sv
// Signals between the trap sequencer and the spill detector.
`timescale 1ns/1ns
`default_nettype none
interface fst_spill_if;
    logic fpOpActive;
    logic fpDivide;
    logic mqCharPhase;
    logic accFinal;
    logic adderP;
    logic adderQ;
    logic accP;
    logic accQ;
    logic clearFlags;
    logic spillSeen;
    logic [3:0] spillCode;
    modport seq (output fpOpActive, fpDivide, mqCharPhase, accFinal, adderP, adderQ, accP, accQ,
                 output clearFlags, input spillSeen, spillCode);
    modport det (input fpOpActive, fpDivide, mqCharPhase, accFinal, adderP, adderQ, accP, accQ,
                 input clearFlags, output spillSeen, spillCode);
endinterface
`default_nettype wire

// file: logic/fst_spill_detect.sv
// Characteristic spill detector that builds the sticky four-bit spill code.
`timescale 1ns/1ns
`default_nettype none
module fst_spill_detect (
    input wire logic core_clk, // Processor clock.
    input wire logic rst, // Asynchronous reset, active high.
    fst_spill_if.det sp // Detector side of the spill signals.
);
    logic [3:0] code;
    logic [3:0] next_code;
    logic mqHit;
    logic accHit;
    logic mqOvf;
    logic accOvf;

    // Overflow is P alone, underflow is P with Q; either is a spill.
    always_comb begin
        mqHit = sp.fpOpActive && sp.mqCharPhase && sp.adderP; // see RULE13
        accHit = sp.fpOpActive && sp.accFinal && sp.accP; // see RULE13
        mqOvf = mqHit && !sp.adderQ; // see RULE11
        accOvf = accHit && !sp.accQ; // see RULE11
        next_code = code;
        if (sp.clearFlags) begin
            next_code = '0;
        end
        // A new spill in the clearing cycle is kept, since the set wins.
        if (mqHit || accHit) begin
            next_code[fst_pkg::CODE_MQ] = (sp.clearFlags ? 1'b0 : code[fst_pkg::CODE_MQ]) | mqHit; // see RULE10
            next_code[fst_pkg::CODE_ACC] = (sp.clearFlags ? 1'b0 : code[fst_pkg::CODE_ACC]) | accHit; // see RULE9
            next_code[fst_pkg::CODE_OVF] = (sp.clearFlags ? 1'b0 : code[fst_pkg::CODE_OVF])
                                           | mqOvf | accOvf; // see RULE8 RULE12
            next_code[fst_pkg::CODE_DIV] = (sp.clearFlags ? 1'b0 : code[fst_pkg::CODE_DIV]) | sp.fpDivide; // see RULE7
        end
    end

    // Sticky code register.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            code <= '0;
        end else begin
            code <= next_code;
        end
    end

    assign sp.spillCode = code;
    assign sp.spillSeen = code[fst_pkg::CODE_ACC] | code[fst_pkg::CODE_MQ];

    property p_ovfOnly;
        @(posedge core_clk) disable iff (rst)
        (accHit && sp.accQ && !mqHit && !sp.clearFlags && !code[fst_pkg::CODE_OVF])
        |=> !code[fst_pkg::CODE_OVF];
    endproperty
    a_ovfOnly: assert property (p_ovfOnly) else $error("Underflow marked as overflow."); // see RULE11

    logic spillSeenD;
    assign spillSeenD = sp.spillSeen;

    property p_mqBit;
        @(posedge core_clk) disable iff (rst)
        mqHit |=> code[fst_pkg::CODE_MQ] && spillSeenD;
    endproperty
    a_mqBit: assert property (p_mqBit) else $error("Register spill not recorded."); // see RULE10
endmodule
`default_nettype wire

// file: logic/fst_trap_unit.sv
// Floating-point spill trap sequencer with trap mode flag and store-trap cycle.
// Behaviour
// RULE1 - A spill while trap mode is on lets the instruction end, then traps to octal 0010.
// RULE2 - The trap stores the faulting instruction address plus one in the address field of word 0000.
// RULE3 - The spill code goes to the decrement field of word zero in the same store cycle.
// RULE4 - Reset turns trap mode on.
// RULE5 - The leave-float-trap instruction turns trap mode off.
// RULE6 - Reset or the enter-float-trap instruction turns trap mode back on.
// RULE7 - Code bit 14 marks a spill during a floating-point divide.
// RULE8 - Code bit 15 marks an overflow in either register.
// RULE9 - Code bit 16 marks a spill in the accumulator characteristic.
// RULE10 - Code bit 17 marks a spill in the multiplier-quotient characteristic.
// RULE11 - Overflow is a one in P alone, not P together with Q.
// RULE12 - Underflow is a one in both P and Q.
// RULE13 - Register spills are seen in the adders, accumulator spills once its characteristic is final.
// RULE14 - A spill sets the trap flip-flop, which suppresses the next instruction and loads a store-trap pseudo op.
// RULE15 - The pseudo op loads address 0000, enables both store controls and starts one execute cycle.
// RULE16 - That execute cycle drives the program counter and spill code onto the storage bus.
// RULE17 - With trap mode off a spill neither stores nor redirects.
`timescale 1ns/1ns
`default_nettype none
module fst_trap_unit (
    input wire logic core_clk, // Processor clock, 10 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic fpOpActive, // Floating-point instruction executing.
    input wire logic fpDivide, // The floating-point op is a divide.
    input wire logic mqCharPhase, // Register characteristic in the adders.
    input wire logic accFinal, // Accumulator characteristic is final.
    input wire logic adderP, // Adder position P.
    input wire logic adderQ, // Adder position Q.
    input wire logic accP, // Accumulator position P.
    input wire logic accQ, // Accumulator position Q.
    input wire logic instrEnd, // Current instruction ends this cycle.
    input wire logic leaveFloatTrapOp, // Leave-float-trap executes.
    input wire logic enterFloatTrapOp, // Enter-float-trap executes.
    input wire logic [14:0] pcValue, // Program counter, instruction plus one.
    input wire logic execDone, // Storage execute cycle finished.
    output logic trapMode, // Trap mode flag.
    output logic trapFlag, // Trap flip-flop.
    output logic suppressNext, // Block the following instruction.
    output logic loadInstrHold, // Load the instruction hold register.
    output logic [35:0] instrHoldValue, // Pseudo store-trap word.
    output logic addrRegLoad, // Load the address register.
    output logic [14:0] addrRegValue, // Address register value.
    output logic storeDecr, // Store decrement control.
    output logic storeAddr, // Store address control.
    output logic startExec, // Start one execute cycle.
    output logic storeBusValid, // Storage bus carries the record.
    output logic [35:0] storeBusData, // Record for word zero.
    output logic [3:0] spillCode // Latched spill code.
);
    typedef enum logic [2:0] {S_IDLE, S_PEND, S_LOAD, S_EXEC, S_REDIR} fst_state_t;

    fst_state_t state;
    fst_state_t next_state;
    logic next_trapMode;
    logic next_trapFlag;
    logic next_suppressNext;
    logic next_loadInstrHold;
    logic [35:0] next_instrHoldValue;
    logic next_addrRegLoad;
    logic [14:0] next_addrRegValue;
    logic next_storeDecr;
    logic next_storeAddr;
    logic next_startExec;
    logic next_storeBusValid;
    logic [35:0] next_storeBusData;
    logic next_clearFlags;
    logic clearFlags;

    fst_spill_if sp ();

    assign sp.fpOpActive = fpOpActive;
    assign sp.fpDivide = fpDivide;
    assign sp.mqCharPhase = mqCharPhase;
    assign sp.accFinal = accFinal;
    assign sp.adderP = adderP;
    assign sp.adderQ = adderQ;
    assign sp.accP = accP;
    assign sp.accQ = accQ;
    assign sp.clearFlags = clearFlags;

    // Spill detector and code builder.
    fst_spill_detect u_detect (
        .core_clk(core_clk),
        .rst(rst),
        .sp(sp)
    );

    // Trap mode flag: leave clears it, enter sets it, enter wins a tie.
    always_comb begin
        next_trapMode = trapMode;
        if (leaveFloatTrapOp) begin
            next_trapMode = 1'b0; // see RULE5
        end
        if (enterFloatTrapOp) begin
            next_trapMode = 1'b1; // see RULE6
        end
    end

    // Mode flag register, set by reset.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trapMode <= fst_pkg::TRAP_MODE_RESET; // see RULE4
        end else begin
            trapMode <= next_trapMode;
        end
    end

    // Trap sequence from detection through store cycle to redirection.
    always_comb begin
        next_state = state;
        next_trapFlag = trapFlag;
        next_suppressNext = 1'b0;
        next_loadInstrHold = 1'b0;
        next_instrHoldValue = instrHoldValue;
        next_addrRegLoad = 1'b0;
        next_addrRegValue = addrRegValue;
        next_storeDecr = storeDecr;
        next_storeAddr = storeAddr;
        next_startExec = 1'b0;
        next_storeBusValid = storeBusValid;
        next_storeBusData = storeBusData;
        next_clearFlags = 1'b0;
        case (state)
            S_IDLE: begin
                // The clear issued on the way out of a trap has not reached the code yet, so it is ignored.
                if (sp.spillSeen && trapMode && !clearFlags) begin
                    next_trapFlag = 1'b1; // see RULE14 RULE17
                    next_state = S_PEND;
                end else if (instrEnd) begin
                    next_clearFlags = 1'b1; // see RULE17
                end
            end
            S_PEND: begin
                // The faulting instruction runs to its end first.
                if (instrEnd) begin
                    next_state = S_LOAD; // see RULE1
                    next_suppressNext = 1'b1; // see RULE14
                    next_loadInstrHold = 1'b1;
                    next_instrHoldValue = '0;
                    next_instrHoldValue[fst_pkg::HOLD_SIGN_IDX] = 1'b1; // see RULE14
                    next_instrHoldValue[fst_pkg::HOLD_BIT9_IDX] = 1'b1;
                    next_addrRegLoad = 1'b1;
                    next_addrRegValue = fst_pkg::TRAP_RECORD_ADDR; // see RULE15
                    next_storeDecr = 1'b1;
                    next_storeAddr = 1'b1;
                end
            end
            S_LOAD: begin
                next_startExec = 1'b1; // see RULE15
                next_storeBusValid = 1'b1; // see RULE16
                next_storeBusData = '0;
                next_storeBusData[fst_pkg::ADDR_FIELD_LSB +: fst_pkg::ADDR_W] = pcValue; // see RULE2
                next_storeBusData[fst_pkg::CODE_FIELD_LSB +: fst_pkg::CODE_W] = sp.spillCode; // see RULE3
                next_state = S_EXEC;
            end
            S_EXEC: begin
                if (execDone) begin
                    next_storeBusValid = 1'b0;
                    next_storeDecr = 1'b0;
                    next_storeAddr = 1'b0;
                    next_addrRegLoad = 1'b1;
                    next_addrRegValue = fst_pkg::TRAP_VECTOR_ADDR; // see RULE1
                    next_state = S_REDIR;
                end
            end
            S_REDIR: begin
                next_trapFlag = 1'b0;
                next_clearFlags = 1'b1;
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            trapFlag <= 1'b0;
            suppressNext <= 1'b0;
            loadInstrHold <= 1'b0;
            instrHoldValue <= '0;
            addrRegLoad <= 1'b0;
            addrRegValue <= '0;
            storeDecr <= 1'b0;
            storeAddr <= 1'b0;
            startExec <= 1'b0;
            storeBusValid <= 1'b0;
            storeBusData <= '0;
            clearFlags <= 1'b0;
            spillCode <= '0;
        end else begin
            state <= next_state;
            trapFlag <= next_trapFlag;
            suppressNext <= next_suppressNext;
            loadInstrHold <= next_loadInstrHold;
            instrHoldValue <= next_instrHoldValue;
            addrRegLoad <= next_addrRegLoad;
            addrRegValue <= next_addrRegValue;
            storeDecr <= next_storeDecr;
            storeAddr <= next_storeAddr;
            startExec <= next_startExec;
            storeBusValid <= next_storeBusValid;
            storeBusData <= next_storeBusData;
            clearFlags <= next_clearFlags;
            spillCode <= sp.spillCode;
        end
    end

    property p_modeLeave;
        @(posedge core_clk) disable iff (rst)
        (leaveFloatTrapOp && !enterFloatTrapOp) |=> !trapMode;
    endproperty
    a_modeLeave: assert property (p_modeLeave) else $error("Trap mode not left."); // see RULE5

    property p_modeEnter;
        @(posedge core_clk) disable iff (rst)
        enterFloatTrapOp |=> trapMode;
    endproperty
    a_modeEnter: assert property (p_modeEnter) else $error("Trap mode not entered."); // see RULE6

    property p_noTrapOff;
        @(posedge core_clk) disable iff (rst)
        (state == S_IDLE && !trapMode) |=> !trapFlag;
    endproperty
    a_noTrapOff: assert property (p_noTrapOff) else $error("Trap taken with mode off."); // see RULE17

    property p_pseudoOp;
        @(posedge core_clk) disable iff (rst)
        $rose(suppressNext) |-> loadInstrHold && instrHoldValue[fst_pkg::HOLD_SIGN_IDX]
            && instrHoldValue[fst_pkg::HOLD_BIT9_IDX] && trapFlag;
    endproperty
    a_pseudoOp: assert property (p_pseudoOp) else $error("Pseudo op malformed."); // see RULE14

    property p_storeSetup;
        @(posedge core_clk) disable iff (rst)
        $rose(suppressNext) |-> addrRegLoad && addrRegValue == fst_pkg::TRAP_RECORD_ADDR
            && storeDecr && storeAddr ##1 startExec ##1 !startExec;
    endproperty
    a_storeSetup: assert property (p_storeSetup) else $error("Store cycle setup wrong."); // see RULE15

    property p_record;
        @(posedge core_clk) disable iff (rst)
        startExec |-> storeBusValid
            && storeBusData[fst_pkg::ADDR_FIELD_LSB +: fst_pkg::ADDR_W] == $past(pcValue)
            && storeBusData[fst_pkg::CODE_FIELD_LSB +: fst_pkg::CODE_W] == spillCode;
    endproperty
    a_record: assert property (p_record) else $error("Record word wrong."); // see RULE2 RULE3 RULE16

    property p_redirect;
        @(posedge core_clk) disable iff (rst)
        (state == S_EXEC && execDone) |=> addrRegLoad && addrRegValue == fst_pkg::TRAP_VECTOR_ADDR;
    endproperty
    a_redirect: assert property (p_redirect) else $error("No redirect to vector."); // see RULE1

    property p_waitEnd;
        @(posedge core_clk) disable iff (rst)
        (state == S_PEND && !instrEnd) |=> !suppressNext;
    endproperty
    a_waitEnd: assert property (p_waitEnd) else $error("Trap before instruction end."); // see RULE1

    c_trapTaken: cover property (@(posedge core_clk) disable iff (rst) startExec);
    c_modeOffSpill: cover property (@(posedge core_clk) disable iff (rst) sp.spillSeen && !trapMode);
    c_divideSpill: cover property (@(posedge core_clk) disable iff (rst) startExec && spillCode[fst_pkg::CODE_DIV]);
endmodule
`default_nettype wire

// file: tb/fst_proc_model.sv
// Processor execute-cycle and core storage model facing the spill trap unit.
`timescale 1ns/1ns
`default_nettype none
module fst_proc_model (
    input wire logic core_clk, // Processor clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic startExec, // Start of one execute cycle.
    input wire logic storeDecr, // Store decrement control.
    input wire logic storeAddr, // Store address control.
    input wire logic storeBusValid, // Storage bus carries the record.
    input wire logic [35:0] storeBusData, // Record for word zero.
    input wire logic [3:0] execDelay, // Extra cycles before the execute cycle ends.
    output logic execDone, // Execute cycle finished pulse.
    output logic [35:0] storedWord, // Contents of word zero.
    output int storeCount // Number of writes into word zero.
);
    logic busy;
    logic [3:0] waitCnt;

    // Runs one execute cycle, promptly or slowly, and writes word zero only with both store controls on.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            execDone <= 1'b0;
            busy <= 1'b0;
            waitCnt <= 4'h0;
            storedWord <= 36'h000000000;
            storeCount <= 0;
        end else begin
            execDone <= 1'b0;
            if (startExec) begin
                busy <= 1'b1;
                waitCnt <= execDelay;
            end else if (busy) begin
                if (waitCnt == 4'h0) begin
                    execDone <= 1'b1;
                    busy <= 1'b0;
                    if (storeBusValid && storeDecr && storeAddr) begin
                        storedWord <= storeBusData;
                        storeCount <= storeCount + 1;
                    end
                end else begin
                    waitCnt <= waitCnt - 4'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/fst_trap_unit_tb.sv
// Self-checking testbench for the floating-point spill trap unit.
`timescale 1ns/1ns
`default_nettype none
module fst_trap_unit_tb;
    logic core_clk, rst, fpOpActive, fpDivide, mqCharPhase, accFinal, adderP, adderQ, accP, accQ;
    logic instrEnd, leaveFloatTrapOp, enterFloatTrapOp, execDone;
    logic [14:0] pcValue;
    logic trapMode, trapFlag, suppressNext, loadInstrHold, addrRegLoad, storeDecr, storeAddr, startExec, storeBusValid;
    logic [35:0] instrHoldValue, storeBusData, storedWord, holdWord;
    logic [14:0] addrRegValue;
    logic [14:0] addrLog [2];
    logic [3:0] spillCode, execDelay;
    logic sawSuppress;
    int storeCount, addrLoads, num_errors, checks_done;
    // Each entry is divide, acc P, acc Q, adder P, adder Q and the expected four-bit code.
    logic [8:0] tab [8] = '{9'h031, 9'h0f3, 9'h086, 9'h0a7, 9'h139, 9'h1ca, 9'h1fb, 9'h12d};

    fst_trap_unit dut_u (.core_clk(core_clk), .rst(rst), .fpOpActive(fpOpActive), .fpDivide(fpDivide),
        .mqCharPhase(mqCharPhase), .accFinal(accFinal), .adderP(adderP), .adderQ(adderQ), .accP(accP),
        .accQ(accQ), .instrEnd(instrEnd), .leaveFloatTrapOp(leaveFloatTrapOp),
        .enterFloatTrapOp(enterFloatTrapOp), .pcValue(pcValue), .execDone(execDone), .trapMode(trapMode),
        .trapFlag(trapFlag), .suppressNext(suppressNext), .loadInstrHold(loadInstrHold),
        .instrHoldValue(instrHoldValue), .addrRegLoad(addrRegLoad), .addrRegValue(addrRegValue),
        .storeDecr(storeDecr), .storeAddr(storeAddr), .startExec(startExec), .storeBusValid(storeBusValid),
        .storeBusData(storeBusData), .spillCode(spillCode));

    fst_proc_model proc_u (.core_clk(core_clk), .rst(rst), .startExec(startExec), .storeDecr(storeDecr),
        .storeAddr(storeAddr), .storeBusValid(storeBusValid), .storeBusData(storeBusData),
        .execDelay(execDelay), .execDone(execDone), .storedWord(storedWord), .storeCount(storeCount));

    // The clock runs at 10 MHz.
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    // Records the address register loads, the suppress pulse and the pseudo instruction word.
    always @(posedge core_clk) begin
        if (addrRegLoad) begin
            if (addrLoads < 2) addrLog[addrLoads] = addrRegValue;
            addrLoads = addrLoads + 1;
        end
        if (suppressNext) sawSuppress = 1'b1;
        if (loadInstrHold) holdWord = instrHoldValue;
    end

    // Compares one value and reports a mismatch.
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits for the given number of falling edges.
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Runs one floating-point instruction with an accumulator phase and a register phase, then checks the spill code and the trap.
    task automatic spill(input logic [8:0] e, input logic expTrap);
        int startCount;
        int n;
        startCount = storeCount;
        addrLoads = 0;
        sawSuppress = 1'b0;
        holdWord = 36'h000000000;
        fpOpActive = 1'b1;
        fpDivide = e[8];
        accFinal = 1'b1;
        {accP, accQ} = e[7:6];
        tick(1);
        {accFinal, accP, accQ} = 3'h0;
        mqCharPhase = 1'b1;
        {adderP, adderQ} = e[5:4];
        tick(1);
        {mqCharPhase, adderP, adderQ} = 3'h0;
        tick(2);
        check(36'(spillCode), 36'(e[3:0]));
        instrEnd = 1'b1;
        tick(1);
        {instrEnd, fpOpActive, fpDivide} = 3'h0;
        n = 0;
        while (expTrap && storeCount == startCount && n < 20) begin
            tick(1);
            n++;
        end
        tick(expTrap ? 4 : 8);
        if (expTrap && n == 20) begin
            num_errors++;
            summarize();
        end else if (expTrap) begin
            check(36'(sawSuppress), 36'h1);
            check(36'({holdWord[35], holdWord[26]}), 36'h3);
            check(36'(addrLoads), 36'h2);
            check(36'(addrLog[0]), 36'h0);
            check(36'(addrLog[1]), 36'h8);
            check(36'(storedWord[14:0]), 36'(pcValue));
            check(36'(storedWord[21:18]), 36'(e[3:0]));
            check(36'({trapFlag, spillCode}), 36'h0);
        end else begin
            check(36'(storeCount - startCount), 36'h0);
            check(36'(addrLoads), 36'h0);
            check(36'({trapFlag, spillCode}), 36'h0);
        end
    endtask

    // Pulses the mode instructions and checks the resulting trap mode.
    task automatic mode(input logic leave, input logic enter, input logic exp);
        leaveFloatTrapOp = leave;
        enterFloatTrapOp = enter;
        tick(1);
        {leaveFloatTrapOp, enterFloatTrapOp} = 2'h0;
        tick(1);
        check(36'(trapMode), 36'(exp));
    endtask

    // Main sequence: eight spill codes, prompt and slow storage, mode changes and a second reset.
    initial begin
        {rst, fpOpActive, fpDivide, mqCharPhase, accFinal, adderP, adderQ, accP, accQ} = 9'h100;
        {instrEnd, leaveFloatTrapOp, enterFloatTrapOp} = 3'h0;
        pcValue = 15'h0000;
        execDelay = 4'h0;
        num_errors = 0;
        checks_done = 0;
        addrLoads = 0;
        tick(6);
        rst = 1'b0;
        tick(1);
        check(36'(trapMode), 36'h1);
        for (int i = 0; i < 8; i++) begin
            execDelay = i[0] ? 4'h3 : 4'h0;
            pcValue = 15'h0100 + 15'(i);
            spill(tab[i], 1'b1);
        end
        mode(1'b1, 1'b0, 1'b0);
        spill(tab[3], 1'b0);
        mode(1'b0, 1'b1, 1'b1);
        pcValue = 15'h7fff;
        spill(tab[7], 1'b1);
        mode(1'b1, 1'b1, 1'b1);
        mode(1'b1, 1'b0, 1'b0);
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        check(36'(trapMode), 36'h1);
        summarize();
    end
endmodule
`default_nettype wire
